// ==== mac_frame_security_policy.sv ====
// security policy of the MAC: mode, per frame protection decision,
// key and offset selection, receive discard and management reports.
// assumes the cipher datapath, handshake and key storage sit outside;
// frame ports are synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - three modes: open, mixed secure and plain, strictly secure
// - current mode is advertised in every beacon parameters field
// - drop plain frame from related peer when its type needs security
// - data frames use the key named by the identifier from above
// - secure commands use a key held for that relationship
// - beacon, acks, rts, cts and two control types always go plain
// - app frames, probe, reservation and pairwise commands may go either way
// - group key commands always go secure within a relationship
// - data and aggregated data always go secure within a relationship
// - unlisted command types are treated as plain frames
// - pairwise and group key commands use offset zero
// - reservation commands use offset equal to payload length
// - aggregated data uses offset equal to aggregation header length
// - mode 0 sends only plain frames and forms no relationship
// - mode 0 discards every received secure frame
// - secure frames with unknown key identifier are reported
// - secure frames failing the integrity check are reported
// - payload encryption is AES-128 in counter mode
// - integrity value is AES-128 chained block authentication
// - a pairwise key never appears in any frame
// - group keys travel only in group key commands, always encrypted
// - each key has its own frame counter and replay counter
// - modes 1 and 2 drop secure frames from unrelated peers
// - reset leaves mode 1 off; it needs an explicit selection
// - mode 2 refuses relationships with peers in mode 0 or 1
module mac_frame_security_policy import sec_policy_pkg::*; #(
  parameter int NKEY = 4,
  parameter int NPEER = 8
) (
  input wire logic sys_clk_i, // 40 MHz clock
  input wire logic reset_i, // async, active high
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [7:0] s_axi_awaddr_i, // write byte address
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write byte enables
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  output logic [1:0] s_axi_bresp_o, // write response code
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  input wire logic [7:0] s_axi_araddr_i, // read byte address
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response code
  input wire tx_req_t tx_req_i, // frame offered for transmit
  output tx_dec_t tx_dec_o, // protection decision, one cycle later
  input wire rx_frm_t rx_frm_i, // received frame summary
  output rx_res_t rx_res_o, // keep or discard, plus reports
  output logic [1:0] beacon_mode_o, // mode for beacon parameters
  output logic aes_ctr_sel_o, // cipher uses AES-128 counter mode
  output logic aes_cbcmac_sel_o // integrity uses AES-128 CBC-MAC
);

  // policy state, key table and bus registers
  logic [1:0] mode_q;
  logic [NPEER-1:0] rel_q;
  logic [1:0] pmode_q [NPEER];
  logic [SLOT_W-1:0] pslot_q [NPEER];
  logic [NKEY-1:0] kval_q;
  logic [TEMPORAL_KEY_IDENTIFIER_W-1:0] ktkid_q [NKEY];
  logic [CNT_W-1:0] sfc_q [NKEY], rpl_q [NKEY];
  logic [CNT_W-1:0] cnt_drop_q, cnt_unk_q, cnt_icv_q;
  tx_dec_t tx_dec_q;
  rx_res_t rx_res_q;
  logic awready_q, bvalid_q, arready_q, rvalid_q, aes_sel_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // protection class of each frame type
  function automatic prot_t prot_of(input frame_t f);
    case (f)
      FT_BEACON, FT_IMM_ACK, FT_BLK_ACK, FT_RTS, FT_CTS, FT_CTRL_A,
      FT_CTRL_R: prot_of = PROT_N;
      FT_APP_CTRL, FT_CRP_REQ, FT_CRP_RSP, FT_PROBE, FT_PTK_CMD,
      FT_APP_CMD: prot_of = PROT_NS;
      FT_GTK_CMD: prot_of = PROT_S;
      FT_DATA, FT_AGG_DATA: prot_of = PROT_S;
      default: prot_of = PROT_N;
    endcase
  endfunction
  // key slot lookup by identifier; lowest valid slot wins
  function automatic logic [SLOT_W:0] key_find(
      input logic [TEMPORAL_KEY_IDENTIFIER_W-1:0] id, input logic [NKEY-1:0] val,
      input logic [NKEY*TEMPORAL_KEY_IDENTIFIER_W-1:0] ids);
    key_find = '0;
    for (int k = NKEY - 1; k >= 0; k--) begin
      if (val[k] && ids[k*TEMPORAL_KEY_IDENTIFIER_W +: TEMPORAL_KEY_IDENTIFIER_W] == id) begin
        key_find = {1'b1, SLOT_W'(k)};
      end
    end
  endfunction
  logic [NKEY*TEMPORAL_KEY_IDENTIFIER_W-1:0] ids_flat;
  for (genvar g = 0; g < NKEY; g++) begin : g_ids
    assign ids_flat[g*TEMPORAL_KEY_IDENTIFIER_W +: TEMPORAL_KEY_IDENTIFIER_W] = ktkid_q[g];
  end
  // write needs address and data together; response blocks the next
  wire wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_q &&
               !awready_q;
  wire [7:0] wk_off = s_axi_awaddr_i - REG_KEY_BASE;
  wire [7:0] wp_off = s_axi_awaddr_i - REG_PEER_BASE;
  wire w_al = s_axi_awaddr_i[1:0] == 2'h0;
  wire w_ctrl = w_al && s_axi_awaddr_i == REG_CTRL;
  wire w_key = w_al && s_axi_awaddr_i >= REG_KEY_BASE &&
               int'(wk_off[7:2]) < NKEY;
  wire w_peer = w_al && s_axi_awaddr_i >= REG_PEER_BASE &&
                int'(wp_off[7:2]) < NPEER;
  wire w_ro = w_al && (s_axi_awaddr_i == REG_STAT ||
              s_axi_awaddr_i == REG_CNT_DROP ||
              s_axi_awaddr_i == REG_CNT_UNK ||
              s_axi_awaddr_i == REG_CNT_ICV);
  wire w_hit = w_ctrl || w_key || w_peer || w_ro;
  wire [SLOT_W-1:0] w_kidx = wk_off[2 +: SLOT_W];
  wire [PEER_W-1:0] w_pidx = wp_off[2 +: PEER_W];
  wire [1:0] w_mode = s_axi_wdata_i[CTRL_MODE_LSB +: 2];
  wire [1:0] w_pmode = s_axi_wdata_i[PEER_MODE_LSB +: 2];
  wire lane0 = s_axi_wstrb_i[0];
  wire lane1 = s_axi_wstrb_i[1];
  // reserved mode code is ignored, keeping the previous mode
  wire mode_wr = wr_go && w_ctrl && lane0 && w_mode != MODE_RSVD;
  wire key_wr = wr_go && w_key && lane0 && lane1;
  wire peer_wr = wr_go && w_peer && lane0;

  // relationship admission: open mode never, strict needs strict peer,
  // mixed needs mixed peer
  wire rel_ok = (mode_q == MODE_STRICT && w_pmode == MODE_STRICT) ||
                (mode_q == MODE_MIXED && w_pmode == MODE_MIXED);
  wire rel_set = s_axi_wdata_i[PEER_REL_BIT] && rel_ok;
  // read decode
  wire rd_go = s_axi_arvalid_i && !rvalid_q && !arready_q;
  wire [7:0] rk_off = s_axi_araddr_i - REG_KEY_BASE;
  wire [7:0] rp_off = s_axi_araddr_i - REG_PEER_BASE;
  wire r_al = s_axi_araddr_i[1:0] == 2'h0;
  wire r_key = r_al && s_axi_araddr_i >= REG_KEY_BASE &&
               int'(rk_off[7:2]) < NKEY;
  wire r_peer = r_al && s_axi_araddr_i >= REG_PEER_BASE &&
                int'(rp_off[7:2]) < NPEER;
  wire [SLOT_W-1:0] r_kidx = rk_off[2 +: SLOT_W];
  wire [PEER_W-1:0] r_pidx = rp_off[2 +: PEER_W];
  wire [31:0] stat_w = (32'(rel_q) << STAT_REL_LSB) |
                       (32'(kval_q) << STAT_KEY_LSB) | 32'(mode_q);
  wire [31:0] key_rd = (32'(kval_q[r_kidx]) << KEY_VALID_BIT) |
                       32'(ktkid_q[r_kidx]);
  wire [31:0] peer_rd = (32'(pslot_q[r_pidx]) << PEER_SLOT_LSB) |
                        (32'(pmode_q[r_pidx]) << PEER_MODE_LSB) |
                        32'(rel_q[r_pidx]);
  wire r_ctrl = r_al && s_axi_araddr_i == REG_CTRL;
  wire r_stat = r_al && s_axi_araddr_i == REG_STAT;
  wire r_drop = r_al && s_axi_araddr_i == REG_CNT_DROP;
  wire r_unk = r_al && s_axi_araddr_i == REG_CNT_UNK;
  wire r_icv = r_al && s_axi_araddr_i == REG_CNT_ICV;
  wire r_hit = r_ctrl || r_stat || r_drop || r_unk || r_icv ||
               r_key || r_peer;
  wire [31:0] rd_mux = r_ctrl ? 32'(mode_q) :
                       r_stat ? stat_w :
                       r_drop ? cnt_drop_q :
                       r_unk ? cnt_unk_q :
                       r_icv ? cnt_icv_q :
                       r_key ? key_rd :
                       r_peer ? peer_rd : 32'h0000_0000;
  // transmit decision
  wire tx_data = tx_req_i.ftype == FT_DATA || tx_req_i.ftype == FT_AGG_DATA;
  wire prot_t tx_pol = prot_of(tx_req_i.ftype);
  wire tx_rel = rel_q[tx_req_i.peer] && mode_q != MODE_OPEN;
  wire tx_need = tx_rel && (tx_pol == PROT_S ||
                 (tx_pol == PROT_NS && tx_req_i.want_sec));
  wire [SLOT_W:0] tx_find = key_find(tx_req_i.temporal_key_identifier, kval_q, ids_flat);
  wire [SLOT_W-1:0] tx_pslot = pslot_q[tx_req_i.peer];
  wire [SLOT_W-1:0] tx_slot = tx_data ? tx_find[SLOT_W-1:0]
                                      : tx_pslot;
  wire tx_key_ok = tx_data ? tx_find[SLOT_W] : kval_q[tx_pslot];
  // group keys must never leave in clear, so a plain group command
  // is stopped rather than sent
  wire tx_gtk_bad = tx_req_i.ftype == FT_GTK_CMD && !tx_need;
  // strict mode sends no data before a relationship exists
  wire tx_nodata = mode_q == MODE_STRICT && tx_data && !tx_rel;
  wire tx_block = (tx_need && !tx_key_ok) || tx_gtk_bad || tx_nodata;
  wire tx_sec = tx_need && !tx_block;
  wire [LEN_W-1:0] tx_eo =
      (tx_req_i.ftype == FT_PTK_CMD ||
       tx_req_i.ftype == FT_GTK_CMD) ? EO_WHOLE :
      (tx_req_i.ftype == FT_CRP_REQ ||
       tx_req_i.ftype == FT_CRP_RSP) ? tx_req_i.pay_len :
      (tx_req_i.ftype == FT_AGG_DATA) ? tx_req_i.agg_len :
      tx_req_i.app_eo;
  wire [CNT_W-1:0] tx_sfc_nx = sfc_q[tx_slot] + CNT_W'(1);
  wire tx_inc = tx_req_i.valid && tx_sec;
  // receive filter
  wire prot_t rx_pol = prot_of(rx_frm_i.ftype);
  wire rx_rel = rel_q[rx_frm_i.peer] && mode_q != MODE_OPEN;
  wire rx_d_open = rx_frm_i.secure && mode_q == MODE_OPEN;
  wire rx_d_norel = rx_frm_i.secure && mode_q != MODE_OPEN &&
                    !rx_rel;
  wire rx_d_plain = !rx_frm_i.secure && rx_rel &&
                    rx_pol == PROT_S;
  wire [SLOT_W:0] rx_find = key_find(rx_frm_i.temporal_key_identifier, kval_q, ids_flat);
  wire [SLOT_W-1:0] rx_slot = rx_find[SLOT_W-1:0];
  wire rx_chk = rx_frm_i.secure && !rx_d_open && !rx_d_norel;
  wire rx_unk = rx_chk && !rx_find[SLOT_W];
  wire rx_icvf = rx_chk && rx_find[SLOT_W] && !rx_frm_i.icv_ok;
  // replay check after integrity, so a forged counter cannot move it
  wire rx_replay = rx_chk && rx_find[SLOT_W] && rx_frm_i.icv_ok &&
                   rx_frm_i.secure_frame_counter <= rpl_q[rx_slot];
  wire rx_drop = rx_d_open || rx_d_norel || rx_d_plain || rx_unk ||
                 rx_icvf || rx_replay;
  wire rx_upd = rx_frm_i.valid && rx_chk && !rx_drop;
  // mode and relationships
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q <= MODE_OPEN;
      rel_q <= '0;
    end else begin
      if (mode_wr) begin
        mode_q <= w_mode;
      end
      if (mode_wr && w_mode == MODE_OPEN) begin
        rel_q <= '0;
      end else if (peer_wr) begin
        rel_q[w_pidx] <= rel_set;
      end
    end
  end
  // peer attributes and key table
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      kval_q <= '0;
      for (int i = 0; i < NPEER; i++) begin
        pmode_q[i] <= MODE_OPEN;
        pslot_q[i] <= '0;
      end
      for (int k = 0; k < NKEY; k++) begin
        ktkid_q[k] <= '0;
      end
    end else begin
      if (peer_wr) begin
        pmode_q[w_pidx] <= w_pmode;
        pslot_q[w_pidx] <= s_axi_wdata_i[PEER_SLOT_LSB +: SLOT_W];
      end
      if (key_wr) begin
        kval_q[w_kidx] <= s_axi_wdata_i[KEY_VALID_BIT];
        ktkid_q[w_kidx] <= s_axi_wdata_i[KEY_TEMPORAL_KEY_IDENTIFIER_LSB +: TEMPORAL_KEY_IDENTIFIER_W];
      end
    end
  end
  // per key counters; a rewritten key restarts both of its counters
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int k = 0; k < NKEY; k++) begin
        sfc_q[k] <= '0;
        rpl_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NKEY; k++) begin
        if (key_wr && w_kidx == SLOT_W'(k)) begin
          sfc_q[k] <= '0;
          rpl_q[k] <= '0;
        end else begin
          if (tx_inc && tx_slot == SLOT_W'(k)) begin
            sfc_q[k] <= tx_sfc_nx;
          end
          if (rx_upd && rx_slot == SLOT_W'(k)) begin
            rpl_q[k] <= rx_frm_i.secure_frame_counter;
          end
        end
      end
    end
  end

  // frame results, one cycle after the request
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_dec_q <= '0;
      rx_res_q <= '0;
    end else begin
      tx_dec_q.valid <= tx_req_i.valid;
      tx_dec_q.secure <= tx_sec;
      tx_dec_q.block <= tx_block;
      tx_dec_q.temporal_key_identifier <= ktkid_q[tx_slot];
      tx_dec_q.eo <= tx_eo;
      tx_dec_q.secure_frame_counter <= tx_sec ? tx_sfc_nx : '0;
      rx_res_q.valid <= rx_frm_i.valid;
      rx_res_q.accept <= rx_frm_i.valid && !rx_drop;
      rx_res_q.drop <= rx_frm_i.valid && rx_drop;
      rx_res_q.unk_key <= rx_frm_i.valid && rx_unk;
      rx_res_q.icv_fail <= rx_frm_i.valid && rx_icvf;
    end
  end

  // management event counters, wrapping
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_drop_q <= '0;
      cnt_unk_q <= '0;
      cnt_icv_q <= '0;
    end else begin
      if (rx_res_q.drop) cnt_drop_q <= cnt_drop_q + CNT_W'(1);
      if (rx_res_q.unk_key) cnt_unk_q <= cnt_unk_q + CNT_W'(1);
      if (rx_res_q.icv_fail) cnt_icv_q <= cnt_icv_q + CNT_W'(1);
    end
  end

  // bus handshakes: ready pulses one cycle, answers wait for ready
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      aes_sel_q <= 1'b1;
    end else begin
      aes_sel_q <= 1'b1;
      awready_q <= wr_go;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
      arready_q <= rd_go;
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= rd_mux;
      end else if (s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // outputs; no port carries key material, so a pairwise key can
  // never reach a frame
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = awready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;
  assign tx_dec_o = tx_dec_q;
  assign rx_res_o = rx_res_q;
  assign beacon_mode_o = mode_q;
  // fixed cipher choices, from a flop that holds 1 from reset on
  assign aes_ctr_sel_o = aes_sel_q;
  assign aes_cbcmac_sel_o = aes_sel_q;
  // checks
  a_open_no_tx_sec: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) mode_q == MODE_OPEN && tx_req_i.valid
    |=> !tx_dec_o.secure) else $error("secure send in mode 0");
  a_fixed_plain: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) tx_req_i.valid && prot_of(tx_req_i.ftype) ==
    PROT_N |=> !tx_dec_o.secure) else $error("plain-only sent secure");
  a_data_secure: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) tx_req_i.valid && tx_data && tx_rel &&
    tx_find[SLOT_W] |=> tx_dec_o.secure) else $error("data not secure");
  a_gtk_never_plain: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) tx_req_i.valid && tx_req_i.ftype == FT_GTK_CMD
    |=> tx_dec_o.secure || tx_dec_o.block) else $error("plain gtk");
  a_key_eo_zero: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) tx_req_i.valid && (tx_req_i.ftype == FT_PTK_CMD
    || tx_req_i.ftype == FT_GTK_CMD) |=> tx_dec_o.eo == EO_WHOLE)
    else $error("key command offset not zero");
  a_agg_eo: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) tx_req_i.valid && tx_req_i.ftype == FT_AGG_DATA
    |=> tx_dec_o.eo == $past(tx_req_i.agg_len))
    else $error("aggregate offset wrong");
  a_open_rx_drop: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) rx_frm_i.valid && rx_frm_i.secure &&
    mode_q == MODE_OPEN |=> rx_res_o.drop && !rx_res_o.accept)
    else $error("secure frame kept in mode 0");
  a_plain_rel_drop: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) rx_frm_i.valid && rx_d_plain
    |=> rx_res_o.drop) else $error("plain frame kept");
  a_unk_report: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) rx_res_o.unk_key |=> cnt_unk_q ==
    $past(cnt_unk_q) + CNT_W'(1)) else $error("unknown key lost");
  a_mode_strict_rel: assert property (@(posedge sys_clk_i)
    disable iff (reset_i) peer_wr && mode_q == MODE_STRICT && w_pmode !=
    MODE_STRICT |=> !rel_q[$past(w_pidx)]) else $error("bad relation");

endmodule // mac_frame_security_policy
`default_nettype wire

// ==== sec_policy_pkg.sv ====
// frame security policy package: modes, frame classes, register map,
// field positions and the structs carried on the frame ports.
// assumes a single clock domain and an AXI4-Lite register port.
`default_nettype none
package sec_policy_pkg;
  // security modes as advertised in beacons
  localparam logic [1:0] MODE_OPEN = 2'h0;
  localparam logic [1:0] MODE_MIXED = 2'h1;
  localparam logic [1:0] MODE_STRICT = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // widths of carried fields
  localparam int TEMPORAL_KEY_IDENTIFIER_W = 8;
  localparam int PEER_W = 3;
  localparam int SLOT_W = 2;
  localparam int LEN_W = 12;
  localparam int CNT_W = 32;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CNT_DROP = 8'h08;
  localparam logic [7:0] REG_CNT_UNK = 8'h0C;
  localparam logic [7:0] REG_CNT_ICV = 8'h10;
  localparam logic [7:0] REG_KEY_BASE = 8'h20;
  localparam logic [7:0] REG_PEER_BASE = 8'h40;

  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int STAT_REL_LSB = 8;
  localparam int STAT_KEY_LSB = 16;
  localparam int KEY_TEMPORAL_KEY_IDENTIFIER_LSB = 0;
  localparam int KEY_VALID_BIT = 8;
  localparam int PEER_REL_BIT = 0;
  localparam int PEER_MODE_LSB = 1;
  localparam int PEER_SLOT_LSB = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [LEN_W-1:0] EO_WHOLE = 12'h000;

  typedef enum logic [4:0] {
    FT_BEACON, FT_IMM_ACK, FT_BLK_ACK, FT_RTS, FT_CTS, FT_CTRL_A,
    FT_CTRL_R, FT_APP_CTRL, FT_CRP_REQ, FT_CRP_RSP, FT_PROBE,
    FT_PTK_CMD, FT_GTK_CMD, FT_APP_CMD, FT_DATA, FT_AGG_DATA,
    FT_OTHER_CMD
  } frame_t;

  // protection class: never, either, always secure
  typedef enum logic [1:0] {PROT_N, PROT_NS, PROT_S} prot_t;

  typedef struct packed {
    logic valid;
    frame_t ftype;
    logic want_sec;
    logic [PEER_W-1:0] peer;
    logic [TEMPORAL_KEY_IDENTIFIER_W-1:0] temporal_key_identifier;
    logic [LEN_W-1:0] pay_len;
    logic [LEN_W-1:0] agg_len;
    logic [LEN_W-1:0] app_eo;
  } tx_req_t;

  typedef struct packed {
    logic valid;
    logic secure;
    logic block;
    logic [TEMPORAL_KEY_IDENTIFIER_W-1:0] temporal_key_identifier;
    logic [LEN_W-1:0] eo;
    logic [CNT_W-1:0] secure_frame_counter;
  } tx_dec_t;

  typedef struct packed {
    logic valid;
    frame_t ftype;
    logic secure;
    logic [PEER_W-1:0] peer;
    logic [TEMPORAL_KEY_IDENTIFIER_W-1:0] temporal_key_identifier;
    logic [CNT_W-1:0] secure_frame_counter;
    logic icv_ok;
  } rx_frm_t;

  typedef struct packed {
    logic valid;
    logic accept;
    logic drop;
    logic unk_key;
    logic icv_fail;
  } rx_res_t;
endpackage
`default_nettype wire

// ==== sec_peer_model.sv ====
// peer mac model: hands the device one received frame summary per send.
// assumes a single caller and the device clock as its own clock.
`timescale 1ns/1ps
`default_nettype none
module sec_peer_model import sec_policy_pkg::*; (
  input wire logic clk_i, // mac clock
  output var rx_frm_t frm_o // frame summary seen by the device
);
  initial frm_o = '0;

  // one cycle per frame; idle fields invert so stale data never matches
  task automatic send(input rx_frm_t f);
    @(posedge clk_i);
    frm_o <= f;
    @(posedge clk_i);
    frm_o <= rx_frm_t'({1'h0, ~f[$bits(rx_frm_t)-2:0]});
  endtask
endmodule // sec_peer_model
`default_nettype wire

// ==== mac_frame_security_policy_tb_top.sv ====
// testbench for the frame security policy: register bus, transmit table,
// receive discards. assumes default key and peer counts.
`timescale 1ns/1ps
`default_nettype none
module mac_frame_security_policy_tb_top
  import sec_policy_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdo;
  logic awr, wr, bv, arr, rv, ctr, cbc;
  logic [1:0] br, rrs, rq, bm;
  tx_req_t tq = '0;
  tx_dec_t td;
  rx_frm_t rf;
  rx_res_t rs;
  int fails = 0, n_compared = 0;

  // 40 MHz
  always #12.5 clk = ~clk;

  mac_frame_security_policy i_dut (
    .sys_clk_i(clk), .reset_i(rst), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rdo),
    .s_axi_rresp_o(rrs), .tx_req_i(tq), .tx_dec_o(td), .rx_frm_i(rf),
    .rx_res_o(rs), .beacon_mode_o(bm), .aes_ctr_sel_o(ctr),
    .aes_cbcmac_sel_o(cbc));

  sec_peer_model i_peer (.clk_i(clk), .frm_o(rf));

  task automatic chk(input string n, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wreg(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
    int t = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge clk);
      t++;
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end while (bv !== 1'h1 && t < 40);
    bry <= 1'h0;
    if (t >= 40) fails++;
    chk("bresp", br, e);
  endtask

  // masked read compare; response code kept in rq
  task automatic rreg(input logic [7:0] a, input logic [31:0] m, e);
    int t = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge clk);
      t++;
      if (arr) arv <= 1'h0;
    end while (rv !== 1'h1 && t < 40);
    rry <= 1'h0;
    rq = rrs;
    if (t >= 40) fails++;
    chk("rdata", rdo & m, e);
  endtask

  // one transmit request; decision read mid-cycle after the taking edge
  task automatic txq(input frame_t f, input logic w);
    @(posedge clk);
    tq <= '{1'h1, f, w, 3'h1, 8'h5A, 12'h123, 12'h045, 12'h0A7};
    @(posedge clk);
    tq.valid <= 1'h0;
    @(negedge clk);
  endtask

  // e is {accept, drop, unknown key, integrity fail}
  task automatic rxq(input frame_t f, input logic s, input logic [2:0] p,
                     input logic [7:0] k, input logic i, input logic [3:0] e);
    i_peer.send('{1'h1, f, s, p, k, 32'h1, i});
    @(negedge clk);
    chk("rx", {rs.valid, rs.accept, rs.drop, rs.unk_key, rs.icv_fail},
        {1'h1, e});
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 160 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    results;
  end

  // main sequence
  initial begin
    int cl, secure_frame_counter = 0;
    logic s;
    logic [11:0] eo;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk("beacon", bm, MODE_OPEN);
    chk("cipher", {ctr, cbc}, 2'h3);
    rreg(REG_CTRL, 32'h3, 32'h0);
    wreg(8'h44, 32'h5, RESP_OKAY);
    rreg(8'h44, 32'h1, 32'h0);
    wreg(8'h20, 32'h15A, RESP_OKAY);
    txq(FT_DATA, 1'h1);
    chk("secure", td.secure, 1'h0);
    rxq(FT_DATA, 1'h1, 3'h1, 8'h5A, 1'h1, 4'h4);
    $display("test mode0 done");
    wreg(REG_CTRL, 32'h2, RESP_OKAY);
    chk("beacon", bm, MODE_STRICT);
    wreg(REG_CTRL, 32'h3, RESP_OKAY);
    rreg(REG_CTRL, 32'h3, 32'h2);
    wreg(8'h44, 32'h3, RESP_OKAY);
    rreg(8'h44, 32'h1, 32'h0);
    wreg(8'h44, 32'h5, RESP_OKAY);
    rreg(8'h44, 32'h1, 32'h1);
    // every frame type, plain and secure wish; class 2 must, 1 may
    for (int f = 0; f < 17; f++) begin
      for (int w = 0; w < 2; w++) begin
        cl = (f == 12 || f == 14 || f == 15) ? 2 : (f > 6 && f < 14);
        s = cl == 2 || (cl == 1 && w == 1);
        eo = (f == 11 || f == 12) ? 12'h000 : (f == 8 || f == 9) ? 12'h123
           : (f == 15) ? 12'h045 : 12'h0A7;
        if (s) secure_frame_counter++;
        txq(frame_t'(f), w[0]);
        chk("secure", td.secure, s);
        chk("eo", td.eo, eo);
        chk("temporal_key_identifier", td.temporal_key_identifier, 8'h5A);
        chk("vld_blk", {td.valid, td.block}, 2'h2);
        chk("sfc", td.secure_frame_counter, s ? secure_frame_counter : 0);
      end
    end
    $display("test transmit done");
    rxq(FT_DATA, 1'h0, 3'h1, 8'h5A, 1'h1, 4'h4);
    rxq(FT_BEACON, 1'h0, 3'h1, 8'h5A, 1'h1, 4'h8);
    rxq(FT_DATA, 1'h1, 3'h2, 8'h5A, 1'h1, 4'h4);
    rxq(FT_DATA, 1'h1, 3'h1, 8'h33, 1'h1, 4'h6);
    rxq(FT_DATA, 1'h1, 3'h1, 8'h5A, 1'h0, 4'h5);
    rxq(FT_DATA, 1'h1, 3'h1, 8'h5A, 1'h1, 4'h8);
    rxq(FT_DATA, 1'h1, 3'h1, 8'h5A, 1'h1, 4'h4);
    rreg(REG_CNT_UNK, 32'hFFFFFFFF, 32'h1);
    rreg(REG_CNT_ICV, 32'hFFFFFFFF, 32'h1);
    rreg(REG_CNT_DROP, 32'hFFFFFFFF, 32'h6);
    $display("test receive done");
    wreg(REG_CTRL, 32'h1, RESP_OKAY);
    chk("beacon", bm, MODE_MIXED);
    wreg(8'h48, 32'h3, RESP_OKAY);
    rreg(8'h48, 32'h1, 32'h1);
    wreg(REG_CTRL, 32'h0, RESP_OKAY);
    rreg(REG_STAT, 32'hFF00, 32'h0);
    txq(FT_GTK_CMD, 1'h1);
    chk("secure", td.secure, 1'h0);
    chk("block", td.block, 1'h1);
    wreg(8'h80, 32'h1, RESP_SLVERR);
    rreg(8'h80, 32'hFFFFFFFF, 32'h0);
    chk("rresp", rq, RESP_SLVERR);
    $display("test modes done");
    results;
  end
endmodule // mac_frame_security_policy_tb_top
`default_nettype wire
